// ===== hw/smcd_regs.sv
// Switch miscellaneous configuration and link-training debug register bank.
// Assumes config and management accesses are single-cycle strobes on clk_in;
// link-training state and straps come from other clock domains or pins.
//
// How it works
// RULE1: The operating-mode word is read-only, built from mode bits, reset 0102h.
// RULE2: The five-bit clock buffer field defaults from a strap in bit 20 and to Fh in bits 19:16, and is writable by management or autoload.
// RULE3: Bit 20 resets to the power-down strap level and, when 1, disables all reference clock outputs.
// RULE4: Bits 18:16 enable each reference clock pair, bit 19 is reserved, bits 19:16 reset to Fh.
// RULE5: Trigger select codes 1 to 11 pick the link-training state that starts debug capture.
// RULE6: Writing 1 to the clear bit empties the debug data buffer.
// RULE7: The debug data word is read-only and readable only through the management port.
// RULE8: The capability header returns identifier 0Dh in bits 7:0.
// RULE9: The next-capability pointer is read-only, resets to C0h and points at the express capability.
// RULE10: Subsystem vendor identifier in bits 15:0 is read-only to config, reset 0000h, loadable by management.
// RULE11: Subsystem device identifier in bits 31:16 is read-only to config, reset 0000h, loadable by management.
// RULE12: Reserved bits read zero and ignore writes, and reserved trigger codes never start capture; bit 19 reads 1 from reset until a management write.
// RULE13: The debug port select picks which port's link-training state is observed.
`timescale 1ns/1ps
`default_nettype none
module smcd_regs (
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // Configuration software access
   input  wire logic        cfg_rd_in,
   input  wire logic        cfg_wr_in,
   input  wire logic [7:0]  cfg_addr_in,
   input  wire logic [31:0] cfg_wdata_in,
   output logic      [31:0] cfg_rdata_out,
   output logic             cfg_ack_out,
   // Management port (SMBus/I2C bridge or EEPROM autoload)
   input  wire logic        mgmt_rd_in,
   input  wire logic        mgmt_wr_in,
   input  wire logic [7:0]  mgmt_addr_in,
   input  wire logic [31:0] mgmt_wdata_in,
   output logic      [31:0] mgmt_rdata_out,
   output logic             mgmt_ack_out,
   // Mode sources
   input  wire logic        vchan_negotiation_pending_in,
   input  wire logic        scan_mode_in,
   input  wire logic [1:0]  package_select_in,
   input  wire logic        physical_layer_select_in,
   input  wire logic        debug_mode_in,
   input  wire logic        fast_mode_in,
   input  wire logic        quiescent_test_n_in,
   input  wire logic        boot_rom_skip_in,
   input  wire logic        refclk_buffer_powerdown_strap_in,
   // Link-training state of each of four ports, packed 4 bits per port
   input  wire logic [15:0] lt_state_in,
   // Reference clock output enables and debug buffer level
   output logic      [2:0]  refclk_out_pair_en_out,
   output logic      [3:0]  dbg_level_out
);
   // ==========================================================================
   // Synchronisers for pins
   localparam logic [8:0] OPMODE_RST_BITS = smcd_pkg::OPMODE_RST[8:0];

   logic [8:0]  mode_s1_reg;
   logic [8:0]  mode_s2_reg;
   logic [8:0]  mode_s3_reg;
   logic [8:0]  mode_reg;
   logic [15:0] lt_s1_reg;
   logic [15:0] lt_s2_reg;
   logic [15:0] lt_s3_reg;
   logic [15:0] lt_reg;
   logic        pd_s1_reg;
   logic        pd_s2_reg;
   logic        pd_s3_reg;
   logic [2:0]  pd_vld_reg;
   logic        strap_done_reg;

   // Mode flops start at the reset word so the word never dips before the pins settle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode_s1_reg <= OPMODE_RST_BITS;
         mode_s2_reg <= OPMODE_RST_BITS;
         mode_s3_reg <= OPMODE_RST_BITS;
         mode_reg    <= OPMODE_RST_BITS;
      end else begin
         mode_s1_reg <= {vchan_negotiation_pending_in, scan_mode_in, package_select_in, physical_layer_select_in,
                         debug_mode_in, fast_mode_in, quiescent_test_n_in, boot_rom_skip_in};
         mode_s2_reg <= mode_s1_reg;
         mode_s3_reg <= mode_s2_reg;
         if (mode_s2_reg == mode_s3_reg) begin
            mode_reg <= mode_s3_reg;                                               // see RULE1
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lt_s1_reg <= 16'h0000;
         lt_s2_reg <= 16'h0000;
         lt_s3_reg <= 16'h0000;
         lt_reg    <= 16'h0000;
      end else begin
         lt_s1_reg <= lt_state_in;
         lt_s2_reg <= lt_s1_reg;
         lt_s3_reg <= lt_s2_reg;
         if (lt_s2_reg == lt_s3_reg) begin
            lt_reg <= lt_s3_reg;
         end
      end
   end

   // Valid shift marks when the third strap flop holds a sample taken after reset
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pd_s1_reg  <= 1'b0;
         pd_s2_reg  <= 1'b0;
         pd_s3_reg  <= 1'b0;
         pd_vld_reg <= 3'h0;
      end else begin
         pd_s1_reg  <= refclk_buffer_powerdown_strap_in;
         pd_s2_reg  <= pd_s1_reg;
         pd_s3_reg  <= pd_s2_reg;
         pd_vld_reg <= {pd_vld_reg[1:0], 1'b1};
      end
   end

   // ==========================================================================
   // Write decode
   function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
      hit = stb && (a == off);
   endfunction

   logic cfg_wr_dbg;
   logic mgmt_wr_dbg;
   logic mgmt_wr_clk;
   logic mgmt_wr_id;
   // Config software writes only the debug control register
   assign cfg_wr_dbg  = hit(cfg_wr_in, cfg_addr_in, smcd_pkg::OFF_DBG_CTRL);
   assign mgmt_wr_dbg = hit(mgmt_wr_in, mgmt_addr_in, smcd_pkg::OFF_DBG_CTRL);
   assign mgmt_wr_clk = hit(mgmt_wr_in, mgmt_addr_in, smcd_pkg::OFF_OPMODE);
   assign mgmt_wr_id  = hit(mgmt_wr_in, mgmt_addr_in, smcd_pkg::OFF_SUBSYS_ID);

   // ==========================================================================
   // Clock buffer control
   logic       clk_pd_reg;
   logic [3:0] clk_en_reg;
   logic       strap_ready;

   // Strap level counts once the third flop holds a valid sample and the second and third flops agree
   assign strap_ready = pd_vld_reg[2] && (pd_s2_reg == pd_s3_reg);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         clk_pd_reg     <= 1'b0;
         clk_en_reg     <= smcd_pkg::CLKEN_RST;                                    // see RULE4
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         if (strap_ready) begin
            clk_pd_reg     <= pd_s3_reg;                                           // see RULE3
            strap_done_reg <= 1'b1;
         end
      end else if (mgmt_wr_clk) begin
         clk_pd_reg <= mgmt_wdata_in[smcd_pkg::CLK_PD_BIT];                        // see RULE2
         clk_en_reg <= {1'b0, mgmt_wdata_in[smcd_pkg::CLK_LO +: 3]};               // see RULE12
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         refclk_out_pair_en_out <= 3'h0;
      end else begin
         // Enables stay off until the strap has been taken
         refclk_out_pair_en_out <= (clk_pd_reg || !strap_done_reg) ? 3'h0 : clk_en_reg[2:0]; // see RULE3, RULE4
      end
   end

   // ==========================================================================
   // Debug control
   logic [1:0] port_sel_reg;
   logic [3:0] trig_sel_reg;
   logic       clr_reg;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         port_sel_reg <= 2'h0;
         trig_sel_reg <= 4'h0;
         clr_reg      <= 1'b0;
      end else if (cfg_wr_dbg || mgmt_wr_dbg) begin
         // Config side wins when both ports write in one cycle
         port_sel_reg <= cfg_wr_dbg ? cfg_wdata_in[smcd_pkg::PSEL_LO +: 2] : mgmt_wdata_in[smcd_pkg::PSEL_LO +: 2];
         trig_sel_reg <= cfg_wr_dbg ? cfg_wdata_in[smcd_pkg::TSEL_LO +: 4] : mgmt_wdata_in[smcd_pkg::TSEL_LO +: 4];
         clr_reg      <= cfg_wr_dbg ? cfg_wdata_in[smcd_pkg::CLR_BIT] : mgmt_wdata_in[smcd_pkg::CLR_BIT];
      end else begin
         clr_reg <= 1'b0;
      end
   end

   // ==========================================================================
   // Trigger and capture buffer
   logic [3:0]  obs_state;
   logic [3:0]  prev_state_reg;
   logic        trig_ok;
   logic        armed_reg;
   logic [31:0] buf_mem [smcd_pkg::DBG_DEPTH];
   logic [3:0]  wr_ptr_reg;
   logic [3:0]  rd_ptr_reg;
   logic [4:0]  count_reg;
   logic        pop;
   logic        trig_hit;
   logic        buf_full;

   localparam logic [4:0] BUF_FULL = 5'(smcd_pkg::DBG_DEPTH);

   assign obs_state = lt_reg[port_sel_reg * 4 +: 4];                               // see RULE13
   assign trig_ok   = (trig_sel_reg >= smcd_pkg::SMCD_LT_DETECT) &&
                      (trig_sel_reg <= smcd_pkg::SMCD_LT_RECOVERY);                // see RULE5, RULE12
   assign pop       = hit(mgmt_rd_in, mgmt_addr_in, smcd_pkg::OFF_DBG_DATA) && (count_reg != 5'h00);
   assign trig_hit  = trig_ok && (obs_state == trig_sel_reg);                      // see RULE5, RULE12
   assign buf_full  = (count_reg == BUF_FULL);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev_state_reg <= 4'h0;
         armed_reg      <= 1'b0;
         wr_ptr_reg     <= 4'h0;
         rd_ptr_reg     <= 4'h0;
         count_reg      <= 5'h00;
      end else begin
         prev_state_reg <= obs_state;
         if (clr_reg) begin                                                        // see RULE6
            armed_reg  <= 1'b0;
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg  <= 5'h00;
         end else begin
            if (trig_hit) begin
               armed_reg <= 1'b1;                                                  // see RULE5
            end
            // The change into the trigger state is the first entry; a full buffer drops new ones
            if ((armed_reg || trig_hit) && obs_state != prev_state_reg && !buf_full) begin
               buf_mem[wr_ptr_reg] <= {12'h000, port_sel_reg, prev_state_reg, obs_state, 10'h000};
               wr_ptr_reg          <= wr_ptr_reg + 4'h1;
               count_reg           <= pop ? count_reg : count_reg + 5'h01;
            end else if (pop) begin
               count_reg <= count_reg - 5'h01;
            end
            if (pop) begin
               rd_ptr_reg <= rd_ptr_reg + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dbg_level_out <= 4'h0;
      end else begin
         // Level saturates at F when every entry is taken
         dbg_level_out <= buf_full ? 4'hF : count_reg[3:0];
      end
   end

   // ==========================================================================
   // Subsystem identity
   logic [15:0] ss_vendor_reg;
   logic [15:0] ss_device_reg;
   // Only the management side loads the identity

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ss_vendor_reg <= smcd_pkg::SUBSYS_RST;
         ss_device_reg <= smcd_pkg::SUBSYS_RST;
      end else if (mgmt_wr_id) begin
         ss_vendor_reg <= mgmt_wdata_in[15:0];                                     // see RULE10
         ss_device_reg <= mgmt_wdata_in[smcd_pkg::DEV_LO +: 16];                   // see RULE11
      end
   end

   // ==========================================================================
   // Read mux
   function automatic logic [31:0] rd_word(input logic [7:0] a, input logic mgmt);
      rd_word = 32'h0000_0000;                                                     // see RULE12
      case (a)
         smcd_pkg::OFF_OPMODE:    rd_word = {11'h000, clk_pd_reg, clk_en_reg, 7'h00, mode_reg};  // see RULE1
         smcd_pkg::OFF_DBG_CTRL:  rd_word = {25'h0, clr_reg, trig_sel_reg, port_sel_reg};
         smcd_pkg::OFF_DBG_DATA:  rd_word = (mgmt && count_reg != 5'h00) ? buf_mem[rd_ptr_reg] : 32'h0; // see RULE7
         smcd_pkg::OFF_CAP_HDR:   rd_word = {16'h0000, smcd_pkg::NEXT_PTR_RST, smcd_pkg::CAP_ID}; // see RULE8, RULE9
         smcd_pkg::OFF_SUBSYS_ID: rd_word = {ss_device_reg, ss_vendor_reg};
         default:                 rd_word = 32'h0000_0000;
      endcase
   endfunction

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cfg_rdata_out  <= 32'h0000_0000;
         cfg_ack_out    <= 1'b0;
         mgmt_rdata_out <= 32'h0000_0000;
         mgmt_ack_out   <= 1'b0;
      end else begin
         // Every strobe is answered exactly one cycle later
         cfg_ack_out    <= cfg_rd_in || cfg_wr_in;
         mgmt_ack_out   <= mgmt_rd_in || mgmt_wr_in;
         cfg_rdata_out  <= cfg_rd_in ? rd_word(cfg_addr_in, 1'b0) : 32'h0000_0000;
         mgmt_rdata_out <= mgmt_rd_in ? rd_word(mgmt_addr_in, 1'b1) : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ===== pkg/smcd_pkg.sv
// Constants for the switch miscellaneous configuration and debug register bank.
// Assumes a 32-bit configuration-space word access and a separate management port.
package smcd_pkg;
   // ==========================================================================
   // Register offsets
   localparam logic [7:0]  OFF_OPMODE     = 8'h98;
   localparam logic [7:0]  OFF_DBG_CTRL   = 8'h9C;
   localparam logic [7:0]  OFF_DBG_DATA   = 8'hAC;
   localparam logic [7:0]  OFF_CAP_HDR    = 8'hB0;
   localparam logic [7:0]  OFF_SUBSYS_ID  = 8'hB4;
   // ==========================================================================
   // Reset values and fixed fields
   localparam logic [15:0] OPMODE_RST     = 16'h0102;
   localparam logic [3:0]  CLKEN_RST      = 4'hF;
   localparam logic [7:0]  CAP_ID         = 8'h0D;
   localparam logic [7:0]  NEXT_PTR_RST   = 8'hC0;
   localparam logic [15:0] SUBSYS_RST     = 16'h0000;
   // ==========================================================================
   // Field positions
   localparam int          CLK_LO         = 16;
   localparam int          CLK_PD_BIT     = 20;
   localparam int          PSEL_LO        = 0;
   localparam int          TSEL_LO        = 2;
   localparam int          CLR_BIT        = 6;
   localparam int          NPTR_LO        = 8;
   localparam int          DEV_LO         = 16;
   localparam int          DBG_DEPTH      = 16;
   // ==========================================================================
   // Link-training states, as trigger select codes
   typedef enum logic [3:0] {
      SMCD_LT_NONE     = 4'h0,
      SMCD_LT_DETECT   = 4'h1,
      SMCD_LT_POLLING  = 4'h2,
      SMCD_LT_CONFIG   = 4'h3,
      SMCD_LT_L0       = 4'h4,
      SMCD_LT_L0S      = 4'h5,
      SMCD_LT_L1       = 4'h6,
      SMCD_LT_L2       = 4'h7,
      SMCD_LT_DISABLE  = 4'h8,
      SMCD_LT_HOTRST   = 4'h9,
      SMCD_LT_LOOPBACK = 4'hA,
      SMCD_LT_RECOVERY = 4'hB
   } smcd_lt_e;
endpackage

// ===== verification/smcd_host_model.sv
// Host model for one register access port of the bank.
// Assumes a one-cycle strobe taken at a rising edge and an ack one cycle later.
`timescale 1ns/1ps
`default_nettype none
module smcd_host_model (
   input  wire logic        clk_in,
   input  wire logic        ack_in,
   input  wire logic [31:0] rdata_in,
   output logic             rd_out,
   output logic             wr_out,
   output logic      [7:0]  addr_out,
   output logic      [31:0] wdata_out
);
   // ==========
   // Idle levels
   initial begin
      rd_out = 1'b0;
      wr_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 32'h0;
   end
   // ==========
   // One access; read data stays unknown when no ack comes
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data, output logic [31:0] q);
      int n;
      n = 0;
      q = 32'hXXXXXXXX;
      @(negedge clk_in);
      rd_out = ~wr;
      wr_out = wr;
      addr_out = addr;
      wdata_out = data;
      @(negedge clk_in);
      rd_out = 1'b0;
      wr_out = 1'b0;
      addr_out = ~addr;
      wdata_out = ~data;
      while (ack_in !== 1'b1 && n < 4) begin
         @(negedge clk_in);
         n++;
      end
      if (ack_in === 1'b1) q = rdata_in;
   endtask
endmodule
`default_nettype wire

// ===== verification/smcd_regs_sva.sv
// Checker for the bank's answer timing and fixed read values.
// Bound to smcd_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module smcd_regs_chk (
   input wire logic        clk_in,
   input wire logic        arst_n_in,
   input wire logic        cfg_rd_in,
   input wire logic        cfg_wr_in,
   input wire logic [7:0]  cfg_addr_in,
   input wire logic [31:0] cfg_wdata_in,
   input wire logic [31:0] cfg_rdata_out,
   input wire logic        cfg_ack_out,
   input wire logic        mgmt_rd_in,
   input wire logic        mgmt_wr_in,
   input wire logic [7:0]  mgmt_addr_in,
   input wire logic [31:0] mgmt_wdata_in,
   input wire logic [31:0] mgmt_rdata_out,
   input wire logic        mgmt_ack_out,
   input wire logic [2:0]  refclk_out_pair_en_out,
   input wire logic [3:0]  dbg_level_out
);
   // ==========
   // Assertions
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_cfg_ack_timing: assert property (cfg_ack_out == $past(cfg_rd_in || cfg_wr_in))
      else $error("cfg ack not one cycle after request");
   a_mgmt_ack_timing: assert property (mgmt_ack_out == $past(mgmt_rd_in || mgmt_wr_in))
      else $error("mgmt ack not one cycle after request");
   a_cap_header_value: assert property (cfg_rd_in && cfg_addr_in == 8'hB0 |=> cfg_rdata_out == 32'h0000C00D)
      else $error("capability header wrong");
   a_debug_cfg_hidden: assert property (cfg_rd_in && cfg_addr_in == 8'hAC |=> cfg_rdata_out == 32'h0)
      else $error("debug data visible on cfg port");
   a_opmode_rsvd_zero: assert property (cfg_rd_in && cfg_addr_in == 8'h98 |=>
      cfg_rdata_out[31:21] == 11'h0 && cfg_rdata_out[15:9] == 7'h0) else $error("mode word reserved bits set");
   a_ctrl_rsvd_zero: assert property (cfg_rd_in && cfg_addr_in == 8'h9C |=> cfg_rdata_out[31:7] == 25'h0)
      else $error("debug control reserved bits set");
   a_unmapped_zero: assert property (cfg_rd_in && !(cfg_addr_in inside {8'h98, 8'h9C, 8'hAC, 8'hB0, 8'hB4})
      |=> cfg_rdata_out == 32'h0) else $error("unmapped read not zero");
   a_refclk_follow: assert property (mgmt_ack_out && $past(mgmt_rd_in && mgmt_addr_in == 8'h98) |->
      refclk_out_pair_en_out == (mgmt_rdata_out[20] ? 3'h0 : mgmt_rdata_out[18:16])) else $error("refclk enables wrong");
   a_clear_flush: assert property ((cfg_wr_in && cfg_addr_in == 8'h9C && cfg_wdata_in[6]) ||
      (mgmt_wr_in && mgmt_addr_in == 8'h9C && mgmt_wdata_in[6]) |-> ##[1:4] dbg_level_out == 4'h0)
      else $error("debug buffer not flushed");
endmodule
bind smcd_regs smcd_regs_chk i_chk (.clk_in, .arst_n_in, .cfg_rd_in, .cfg_wr_in, .cfg_addr_in, .cfg_wdata_in,
   .cfg_rdata_out, .cfg_ack_out, .mgmt_rd_in, .mgmt_wr_in, .mgmt_addr_in, .mgmt_wdata_in, .mgmt_rdata_out,
   .mgmt_ack_out, .refclk_out_pair_en_out, .dbg_level_out);
`default_nettype wire

// ===== verification/smcd_regs_test.sv
// Self-checking bench for the configuration and debug register bank.
// Two host models drive the config and management ports; pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module smcd_regs_test;
   // ==========
   // Signals
   logic        clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        cfg_rd, cfg_wr, cfg_ack, mgmt_rd, mgmt_wr, mgmt_ack;
   logic [7:0]  cfg_addr, mgmt_addr;
   logic [31:0] cfg_wdata, cfg_rdata, mgmt_wdata, mgmt_rdata, q;
   logic [8:0]  mode = 9'h0D5;
   logic        strap = 1'b0;
   logic [15:0] lt = 16'h0;
   logic [2:0]  refclk;
   logic [3:0]  lvl;
   int          error_cnt = 0;
   int          checks = 0;
   always #10 clk_in = ~clk_in;
   // ==========
   // Instances
   smcd_regs i_smcd_regs (.clk_in, .arst_n_in, .cfg_rd_in(cfg_rd), .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr),
      .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata), .cfg_ack_out(cfg_ack), .mgmt_rd_in(mgmt_rd),
      .mgmt_wr_in(mgmt_wr), .mgmt_addr_in(mgmt_addr), .mgmt_wdata_in(mgmt_wdata), .mgmt_rdata_out(mgmt_rdata),
      .mgmt_ack_out(mgmt_ack), .vchan_negotiation_pending_in(mode[8]), .scan_mode_in(mode[7]),
      .package_select_in(mode[6:5]), .physical_layer_select_in(mode[4]), .debug_mode_in(mode[3]),
      .fast_mode_in(mode[2]), .quiescent_test_n_in(mode[1]), .boot_rom_skip_in(mode[0]),
      .refclk_buffer_powerdown_strap_in(strap), .lt_state_in(lt), .refclk_out_pair_en_out(refclk),
      .dbg_level_out(lvl));
   smcd_host_model i_cfg_host (.clk_in, .ack_in(cfg_ack), .rdata_in(cfg_rdata), .rd_out(cfg_rd), .wr_out(cfg_wr),
      .addr_out(cfg_addr), .wdata_out(cfg_wdata));
   smcd_host_model i_mgmt_host (.clk_in, .ack_in(mgmt_ack), .rdata_in(mgmt_rdata), .rd_out(mgmt_rd),
      .wr_out(mgmt_wr), .addr_out(mgmt_addr), .wdata_out(mgmt_wdata));
   // ==========
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cr(input logic [7:0] a, input logic [31:0] e);
      i_cfg_host.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic mr(input logic [7:0] a, input logic [31:0] e);
      i_mgmt_host.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic cw(input logic [7:0] a, input logic [31:0] d);
      i_cfg_host.xfer(1'b1, a, d, q);
   endtask
   task automatic mw(input logic [7:0] a, input logic [31:0] d);
      i_mgmt_host.xfer(1'b1, a, d, q);
   endtask
   task automatic lt_step(input logic [3:0] s);
      @(negedge clk_in);
      lt = {8'h00, s, s ^ 4'h5};
      repeat (8) @(negedge clk_in);
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========
   // Tests
   initial begin
      repeat (12) @(negedge clk_in);
      arst_n_in = 1'b1;
      i_cfg_host.xfer(1'b0, 8'h98, 32'h0, q);
      chk(q & 32'hFFEFFFFF, 32'h000F0102);
      repeat (6) @(negedge clk_in);
      chk({29'h0, refclk}, 32'h7);
      cr(8'h98, 32'h000F00D5);
      cw(8'h98, 32'hFFFFFFFF);
      cr(8'h98, 32'h000F00D5);
      mw(8'h98, 32'hFFF0FFFF);
      cr(8'h98, 32'h001000D5);
      chk({29'h0, refclk}, 32'h0);
      mw(8'h98, 32'h000D0000);
      mr(8'h98, 32'h000500D5);
      chk({29'h0, refclk}, 32'h5);
      cr(8'h9C, 32'h0);
      cw(8'h9C, 32'hFFFFFFBF);
      cr(8'h9C, 32'h0000003F);
      for (int c = 1; c < 12; c++) begin
         cw(8'h9C, {26'h0, c[3:0], 2'h0});
         cr(8'h9C, {26'h0, c[3:0], 2'h0});
      end
      cr(8'hB0, 32'h0000C00D);
      mw(8'hB0, 32'hFFFFFFFF);
      cr(8'hB0, 32'h0000C00D);
      cr(8'hB4, 32'h0);
      cw(8'hB4, 32'h12345678);
      cr(8'hB4, 32'h0);
      mw(8'hB4, 32'h5A5AA5A5);
      cr(8'hB4, 32'h5A5AA5A5);
      cr(8'h00, 32'h0);
      lt_step(4'h1);
      cw(8'h9C, 32'h9);
      lt_step(4'h2);
      lt_step(4'h3);
      lt_step(4'h4);
      chk({28'h0, lvl}, 32'h3);
      cr(8'hAC, 32'h0);
      mr(8'hAC, 32'h00044800);
      repeat (2) @(negedge clk_in);
      chk({28'h0, lvl}, 32'h2);
      mr(8'hAC, 32'h00048C00);
      cw(8'h9C, 32'h40);
      repeat (4) @(negedge clk_in);
      chk({28'h0, lvl}, 32'h0);
      cr(8'h9C, 32'h0);
      cw(8'h9C, 32'h31);
      lt_step(4'hC);
      lt_step(4'h3);
      chk({28'h0, lvl}, 32'h0);
      @(negedge clk_in);
      arst_n_in = 1'b0;
      strap = 1'b1;
      repeat (2) @(negedge clk_in);
      arst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      chk({29'h0, refclk}, 32'h0);
      cr(8'h98, 32'h001F00D5);
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire
